// *** include/tlb_consts.svh ***
`ifndef TLB_CONSTS_SVH
`define TLB_CONSTS_SVH

// register number layout
`define TLB_REGNUM_W      7
`define TLB_SET_BIT       6
`define TLB_WORD_BIT      0
// word 0 fields
`define TLB_W0_TAG_HI     31
`define TLB_W0_TAG_LO     15
`define TLB_W0_VALID      14
`define TLB_W0_SUP_READ   13
`define TLB_W0_SUP_WRITE  12
`define TLB_W0_SUP_EXEC   11
`define TLB_W0_USER_READ  10
`define TLB_W0_USER_WRITE 9
`define TLB_W0_USER_EXEC  8
`define TLB_W0_TASK_HI    7
`define TLB_W0_TASK_LO    0
`define TLB_W0_MASK       32'hFFFFFFFF
// word 1 fields
`define TLB_W1_PAGE_HI    31
`define TLB_W1_PAGE_LO    10
`define TLB_W1_PROG_HI    7
`define TLB_W1_PROG_LO    6
`define TLB_W1_RECENT     1
`define TLB_W1_IO         0
`define TLB_W1_MASK       32'hFFFFFCC3
// reset value of every entry word
`define TLB_WORD_RESET    32'h00000000

`endif

// *** include/tlb_pkg.sv ***
package tlb_pkg;
	typedef enum logic [1:0] {
		TLB_PG_1K = 2'b00,
		TLB_PG_2K = 2'b01,
		TLB_PG_4K = 2'b10,
		TLB_PG_8K = 2'b11
	} tlb_page_t;

	typedef enum logic [1:0] {
		TLB_ACC_LOAD  = 2'b00,
		TLB_ACC_STORE = 2'b01,
		TLB_ACC_FETCH = 2'b10,
		TLB_ACC_NONE  = 2'b11
	} tlb_access_t;
endpackage

// *** src/tlb_buffer.sv ***
`timescale 1ns/100ps
`include "tlb_consts.svh"
// How it works
// RQ1 - 128 software registers of 32 bits make 64 two-word entries.
// RQ2 - reserved bits read zero; writing ones there changes nothing.
// RQ3 - entries reached only by supervisor move instructions, not memory access.
// RQ4 - register number is bits 6-0 of a general register value.
// RQ5 - even register holds tag word, following odd holds page word.
// RQ6 - numbers 0-63 are set zero lines, 64-127 set one lines.
// RQ7 - tag bits 31-15 match top 17/16/15/14 address bits per page size.
// RQ8 - software fills low tag bits with address bits or zeros per size.
// RQ9 - bit 14 marks entry valid; invalid entries never translate.
// RQ10 - supervisor load, store, fetch need bits 13, 12, 11.
// RQ11 - user load, store, fetch need bits 10, 9, 8.
// RQ12 - task tag bits 7-0 must equal current process identifier.
// RQ13 - physical address is page number joined with untranslated offset.
// RQ14 - software fills low page bits with address bits or zeros.
// RQ15 - page word bits 7-6 drive the programmable output pins.
// RQ16 - page word bit 1 is line recency flag, same in both sets.
// RQ17 - every valid translation marks other set least recent, even if denied.
// RQ18 - page word bit 0 selects memory space or input/output space.
// RQ19 - line index sits just above page offset; both sets compared.
// RQ20 - no valid match signals miss; permission failure signals violation.
// RQ21 - two-bit page size setting selects 1, 2, 4 or 8 kb.
module tlb_buffer #(
	parameter int LINES = 32
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// configuration
	input  wire logic [7:0]           process_ident,
	input  wire tlb_pkg::tlb_page_t   page_size,
	// supervisor move port
	input  wire logic                 mv_req,
	input  wire logic                 mv_write,
	input  wire logic                 mv_supervisor,
	input  wire logic [31:0]          mv_gpr_num,
	input  wire logic [31:0]          mv_wdata,
	output logic      [31:0]          mv_rdata,
	output logic                      mv_ack,
	output logic                      mv_priv_fault,
	// translation request
	input  wire logic                 xl_req,
	input  wire logic [31:0]          xl_vaddr,
	input  wire tlb_pkg::tlb_access_t xl_access,
	input  wire logic                 xl_supervisor,
	// translation answer
	output logic                      xl_done,
	output logic      [31:0]          xl_paddr,
	output logic                      xl_hit,
	output logic                      xl_miss,
	output logic                      xl_prot_fault,
	output logic                      xl_io_space,
	output logic      [1:0]           prog_out_pins
);
	import tlb_pkg::*;

	localparam int IDX_W = $clog2(LINES);

	// entry storage, one array per word, indexed by set and line
	logic [31:0] tag_word  [2][LINES];
	logic [31:0] page_word [2][LINES];
	logic [31:0] next_tag_word  [2][LINES];
	logic [31:0] next_page_word [2][LINES];

	// registered outputs
	logic [31:0] next_mv_rdata;
	logic        next_mv_ack;
	logic        next_mv_priv_fault;
	logic        next_xl_done;
	logic [31:0] next_xl_paddr;
	logic        next_xl_hit;
	logic        next_xl_miss;
	logic        next_xl_prot_fault;
	logic        next_xl_io_space;
	logic [1:0]  next_prog_out_pins;

	// offset width for a page size
	function automatic logic [3:0] offset_bits(input tlb_page_t pg);
		case (pg)
			TLB_PG_1K: offset_bits = 4'hA;
			TLB_PG_2K: offset_bits = 4'hB;
			TLB_PG_4K: offset_bits = 4'hC;
			TLB_PG_8K: offset_bits = 4'hD;
			default:   offset_bits = 4'hA;
		endcase
	endfunction

	// mask of low bits that pass untranslated
	function automatic logic [31:0] low_mask(input tlb_page_t pg);
		low_mask = (32'h00000001 << offset_bits(pg)) - 32'h00000001;
	endfunction

	// permission bit for mode and access kind
	function automatic logic perm_ok(input logic [31:0] w0, input logic sup,
					input tlb_access_t acc);
		case (acc)
			TLB_ACC_LOAD:  perm_ok = sup ? w0[`TLB_W0_SUP_READ]  : w0[`TLB_W0_USER_READ];  // RQ10 RQ11
			TLB_ACC_STORE: perm_ok = sup ? w0[`TLB_W0_SUP_WRITE] : w0[`TLB_W0_USER_WRITE]; // RQ10 RQ11
			TLB_ACC_FETCH: perm_ok = sup ? w0[`TLB_W0_SUP_EXEC]  : w0[`TLB_W0_USER_EXEC];  // RQ10 RQ11
			default:       perm_ok = 1'b1;
		endcase
	endfunction

	// lookup decode
	logic [IDX_W-1:0] line_idx;
	logic [31:0]      tag_cmp_mask;
	logic [1:0]       set_match;
	logic             hit_set;
	logic             any_hit;
	logic [31:0]      hit_w0;
	logic [31:0]      hit_w1;

	// index and compare of both sets
	always_comb begin
		logic [31:0] shifted;
		shifted      = xl_vaddr >> offset_bits(page_size); // RQ21
		line_idx     = shifted[IDX_W-1:0]; // RQ19
		// low tag bits drop out of the compare as the page grows
		tag_cmp_mask = 32'hFFFF8000 << page_size; // RQ7
		for (int s = 0; s < 2; s++) begin
			set_match[s] = tag_word[s][line_idx][`TLB_W0_VALID] // RQ9
				&& (((tag_word[s][line_idx] ^ xl_vaddr) & tag_cmp_mask) == 32'h00000000) // RQ7
				&& (tag_word[s][line_idx][`TLB_W0_TASK_HI:`TLB_W0_TASK_LO]
					== process_ident); // RQ12
		end
		any_hit = |set_match; // RQ19
		hit_set = ~set_match[0];
		hit_w0  = tag_word[hit_set][line_idx];
		hit_w1  = page_word[hit_set][line_idx];
	end

	// move port decode: number from low seven bits only
	logic [`TLB_REGNUM_W-1:0] reg_num;
	logic                     reg_set;
	logic                     reg_odd;
	logic [4:0]               reg_line;
	logic                     mv_ok;
	always_comb begin
		reg_num  = mv_gpr_num[`TLB_REGNUM_W-1:0]; // RQ4
		reg_set  = reg_num[`TLB_SET_BIT]; // RQ6
		reg_odd  = reg_num[`TLB_WORD_BIT]; // RQ5
		reg_line = reg_num[5:1]; // RQ6
		mv_ok    = mv_req && mv_supervisor; // RQ3
	end

	// next state of entries and outputs
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			for (int l = 0; l < LINES; l++) begin
				next_tag_word[s][l]  = tag_word[s][l];
				next_page_word[s][l] = page_word[s][l];
			end
		end
		next_mv_rdata      = mv_rdata;
		next_mv_ack        = 1'b0;
		next_mv_priv_fault = 1'b0;
		next_xl_done       = 1'b0;
		next_xl_paddr      = xl_paddr;
		next_xl_hit        = 1'b0;
		next_xl_miss       = 1'b0;
		next_xl_prot_fault = 1'b0;
		next_xl_io_space   = xl_io_space;
		next_prog_out_pins = prog_out_pins;

		// translation
		if (xl_req) begin
			next_xl_done = 1'b1;
			if (any_hit) begin
				next_xl_paddr = (hit_w1 & ~low_mask(page_size))
					| (xl_vaddr & low_mask(page_size)); // RQ13
				next_xl_io_space   = hit_w1[`TLB_W1_IO]; // RQ18
				next_prog_out_pins = hit_w1[`TLB_W1_PROG_HI:`TLB_W1_PROG_LO]; // RQ15
				if (perm_ok(hit_w0, xl_supervisor, xl_access))
					next_xl_hit = 1'b1;
				else
					next_xl_prot_fault = 1'b1; // RQ20
				// other set becomes least recent in both entries
				for (int s = 0; s < 2; s++)
					next_page_word[s][line_idx][`TLB_W1_RECENT] = ~hit_set; // RQ16 RQ17
			end else begin
				next_xl_miss = 1'b1; // RQ20
			end
		end

		// supervisor moves; a write in the same cycle overrides usage update
		if (mv_req) begin
			next_mv_ack        = 1'b1;
			next_mv_priv_fault = ~mv_supervisor; // RQ3
		end
		if (mv_ok) begin
			if (mv_write) begin
				if (reg_odd)
					next_page_word[reg_set][reg_line] = mv_wdata & `TLB_W1_MASK; // RQ2 RQ5
				else
					next_tag_word[reg_set][reg_line] = mv_wdata & `TLB_W0_MASK; // RQ2 RQ5
			end else begin
				next_mv_rdata = reg_odd ? page_word[reg_set][reg_line]
					: tag_word[reg_set][reg_line]; // RQ1 RQ2
			end
		end
	end

	// register everything
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < 2; s++) begin
				for (int l = 0; l < LINES; l++) begin
					tag_word[s][l]  <= `TLB_WORD_RESET;
					page_word[s][l] <= `TLB_WORD_RESET;
				end
			end
			mv_rdata      <= 32'h00000000;
			mv_ack        <= 1'b0;
			mv_priv_fault <= 1'b0;
			xl_done       <= 1'b0;
			xl_paddr      <= 32'h00000000;
			xl_hit        <= 1'b0;
			xl_miss       <= 1'b0;
			xl_prot_fault <= 1'b0;
			xl_io_space   <= 1'b0;
			prog_out_pins <= 2'h0;
		end else begin
			tag_word      <= next_tag_word;
			page_word     <= next_page_word;
			mv_rdata      <= next_mv_rdata;
			mv_ack        <= next_mv_ack;
			mv_priv_fault <= next_mv_priv_fault;
			xl_done       <= next_xl_done;
			xl_paddr      <= next_xl_paddr;
			xl_hit        <= next_xl_hit;
			xl_miss       <= next_xl_miss;
			xl_prot_fault <= next_xl_prot_fault;
			xl_io_space   <= next_xl_io_space;
			prog_out_pins <= next_prog_out_pins;
		end
	end
endmodule

// *** verification/tlb_monitor.sv ***
`timescale 1ns/100ps
module tlb_monitor (
	// clock and reset
	input logic               clock,
	input logic               rst_n,
	// configuration
	input tlb_pkg::tlb_page_t page_size,
	// move port
	input logic               mv_req,
	input logic               mv_supervisor,
	input logic               mv_ack,
	input logic               mv_priv_fault,
	input logic [31:0]        mv_rdata,
	// translation port
	input logic               xl_req,
	input logic [31:0]        xl_vaddr,
	input logic               xl_done,
	input logic               xl_hit,
	input logic               xl_miss,
	input logic               xl_prot_fault,
	input logic [31:0]        xl_paddr
);
	import tlb_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// move handshake and refusal
	a_move_acked: assert property (mv_req |=> mv_ack)
		else $error("move not acknowledged");
	a_user_refused: assert property (mv_req && !mv_supervisor |=> mv_priv_fault && $stable(mv_rdata))
		else $error("user move not refused");
	a_ack_no_req: assert property (!mv_req |=> !mv_ack && !mv_priv_fault)
		else $error("move answer without request");
	// lookup answer
	a_lookup_done: assert property (xl_req |=> xl_done)
		else $error("lookup not answered");
	a_done_no_req: assert property (!xl_req |=> !(xl_done || xl_hit || xl_miss || xl_prot_fault))
		else $error("lookup answer without request");
	a_one_outcome: assert property (xl_done |-> $onehot({xl_hit, xl_miss, xl_prot_fault}))
		else $error("lookup outcome not unique");
	// address forming
	a_offset_kept: assert property (xl_req ##1 xl_hit |-> xl_paddr[9:0] == $past(xl_vaddr[9:0]))
		else $error("page offset altered");
	a_big_offset: assert property (xl_req && page_size == TLB_PG_8K ##1 xl_hit |->
		xl_paddr[12:0] == $past(xl_vaddr[12:0]))
		else $error("large page offset altered");
	a_miss_holds: assert property (xl_miss |-> $stable(xl_paddr))
		else $error("address changed on miss");
	// main scenarios
	cover property (xl_hit);
	cover property (xl_prot_fault);
	cover property (mv_priv_fault);
endmodule

bind tlb_buffer tlb_monitor u_mon (.clock, .rst_n, .page_size, .mv_req, .mv_supervisor, .mv_ack,
	.mv_priv_fault, .mv_rdata, .xl_req, .xl_vaddr, .xl_done, .xl_hit, .xl_miss, .xl_prot_fault,
	.xl_paddr);

// *** verification/tlb_pipe_model.sv ***
`timescale 1ns/100ps
module tlb_pipe_model (
	// clock
	input  logic                 clock,
	// move instruction side
	output logic                 mv_req,
	output logic                 mv_write,
	output logic                 mv_supervisor,
	output logic [31:0]          mv_gpr_num,
	output logic [31:0]          mv_wdata,
	// address path side
	output logic                 xl_req,
	output tlb_pkg::tlb_access_t xl_access,
	output logic                 xl_supervisor,
	output logic [31:0]          xl_vaddr
);
	import tlb_pkg::*;
	// idle levels at time zero
	initial begin
		{mv_req, mv_write, mv_supervisor, mv_gpr_num, mv_wdata} = '0;
		{xl_req, xl_supervisor, xl_vaddr} = '0;
		xl_access = TLB_ACC_NONE;
	end
	// one move, register number carried in a general register value
	task automatic mv(input logic w, s, input logic [31:0] n, d);
		@(posedge clock);
		#1 {mv_req, mv_write, mv_supervisor, mv_gpr_num, mv_wdata} = {1'b1, w, s, n, d};
		@(posedge clock);
		#1 mv_req = 1'b0;
		mv_gpr_num = ~mv_gpr_num; // released lines do not keep old value
		mv_wdata = ~mv_wdata;
	endtask
	// one lookup pulse
	task automatic lk(input tlb_access_t a, input logic s, input logic [31:0] v);
		@(posedge clock);
		#1 xl_req = 1'b1;
		xl_access = a;
		xl_supervisor = s;
		xl_vaddr = v;
		@(posedge clock);
		#1 xl_req = 1'b0;
		xl_vaddr = ~xl_vaddr;
	endtask
endmodule

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
	import tlb_pkg::*;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  process_ident = 8'h5A;
	tlb_page_t   page_size = TLB_PG_1K;
	tlb_access_t xl_access;
	logic        mv_req, mv_write, mv_supervisor, mv_ack, mv_priv_fault;
	logic        xl_req, xl_supervisor, xl_done, xl_hit, xl_miss, xl_prot_fault, xl_io_space;
	logic [1:0]  prog_out_pins;
	logic [31:0] mv_gpr_num, mv_wdata, mv_rdata, xl_vaddr, xl_paddr, m, r;
	logic [31:0] va = 32'h123DD678;
	int          bad_count = 0, samples_checked = 0, cycles = 0;

	always #20 clock = ~clock;
	tlb_pipe_model pm (.clock, .mv_req, .mv_write, .mv_supervisor, .mv_gpr_num, .mv_wdata, .xl_req,
		.xl_access, .xl_supervisor, .xl_vaddr);
	tlb_buffer dut (.clock, .rst_n, .process_ident, .page_size, .mv_req, .mv_write, .mv_supervisor,
		.mv_gpr_num, .mv_wdata, .mv_rdata, .mv_ack, .mv_priv_fault, .xl_req, .xl_vaddr, .xl_access,
		.xl_supervisor, .xl_done, .xl_paddr, .xl_hit, .xl_miss, .xl_prot_fault, .xl_io_space,
		.prog_out_pins);

	// compare and count
	task automatic chk(input logic [35:0] g, e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	// supervisor read with expected word
	task automatic rd(input logic [31:0] n, e);
		pm.mv(1'b0, 1'b1, n, 32'h0);
		chk({4'h0, mv_rdata}, {4'h0, e});
	endtask
	// verdict
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		repeat (5) @(posedge clock);
		#1 rst_n = 1'b1;
		rd(32'h0, 32'h0);
		rd(32'h7F, 32'h0);
		pm.mv(1'b1, 1'b1, 32'hFFFFFF41, 32'hFFFFFFFD);
		rd(32'h41, 32'hFFFFFCC1);
		pm.mv(1'b1, 1'b0, 32'h41, 32'h0);
		chk(mv_priv_fault, 1'b1);
		rd(32'h41, 32'hFFFFFCC1);
		// set zero line zero, 1k page
		pm.mv(1'b1, 1'b1, 32'h0, 32'h12347F5A);
		pm.mv(1'b1, 1'b1, 32'h1, 32'hABCDE441);
		pm.lk(TLB_ACC_LOAD, 1'b1, 32'h12340123);
		chk({xl_hit, xl_io_space, prog_out_pins, xl_paddr}, {4'hD, 32'hABCDE523});
		rd(32'h1, 32'hABCDE443);
		rd(32'h41, 32'hFFFFFCC3);
		// one permission bit at a time, granted then refused in the other mode
		for (int k = 0; k < 6; k++) begin
			pm.mv(1'b1, 1'b1, 32'h0, 32'h1234405A | (32'h1 << (13 - k)));
			pm.lk(tlb_access_t'(k % 3), k < 3, 32'h12340123);
			chk({xl_hit, xl_miss, xl_prot_fault}, 3'b100);
			pm.lk(tlb_access_t'(k % 3), k >= 3, 32'h12340123);
			chk({xl_hit, xl_miss, xl_prot_fault}, 3'b001);
		end
		pm.mv(1'b1, 1'b1, 32'h0, 32'h12343F5A);
		pm.lk(TLB_ACC_LOAD, 1'b1, 32'h12340123);
		chk({xl_hit, xl_miss, xl_prot_fault}, 3'b010);
		pm.mv(1'b1, 1'b1, 32'h0, 32'h12347F5A);
		process_ident = 8'hA5;
		pm.lk(TLB_ACC_LOAD, 1'b1, 32'h12340123);
		chk({xl_hit, xl_miss, xl_prot_fault}, 3'b010);
		process_ident = 8'h5A;
		// every page size, set one, line from bits above the offset
		for (int k = 0; k < 4; k++) begin
			m = 32'hFFFFFC00 << k;
			r = 32'h40 + 2 * ((va >> (10 + k)) & 32'h1F);
			page_size = tlb_page_t'(k);
			pm.mv(1'b1, 1'b1, r, (va & (m << 5)) | 32'h7F5A);
			pm.mv(1'b1, 1'b1, r + 1, 32'h87654000);
			pm.lk(TLB_ACC_LOAD, 1'b1, va);
			chk({xl_hit, xl_paddr}, {1'b1, (32'h87654000 & m) | (va & ~m)});
		end
		complete_run();
	end
endmodule
